//--- can_btm_pkg.sv
package can_btm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned ADDR_W = 12;              // Byte address width
    localparam int unsigned IDX_W  = 10;              // Register index width

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MASTER_CTRL = 10'h318;  // Config mode request
    localparam logic [IDX_W-1:0] IDX_CONFIG_ONE  = 10'h31C;  // Quantum prescaler
    localparam logic [IDX_W-1:0] IDX_SEG_LOW     = 10'h31E;  // Segment timing config low
    localparam logic [IDX_W-1:0] IDX_JUMP_HIGH   = 10'h31F;  // Jump width config high
    localparam logic [IDX_W-1:0] IDX_STATUS      = 10'h320;  // Timing state, read only

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CFG_REQ_BIT = 7;          // Config mode request
    localparam int unsigned TRIPLE_BIT  = 7;          // Triple sample select
    localparam int unsigned PH2_MSB     = 6;          // Phase segment two field
    localparam int unsigned PH2_LSB     = 4;
    localparam int unsigned PH1_MSB     = 3;          // Phase segment one field
    localparam int unsigned PH1_LSB     = 0;
    localparam int unsigned SJW_MSB     = 1;          // Jump width, bits 9:8 of pair
    localparam int unsigned SJW_LSB     = 0;

    // Reset values
    localparam logic [7:0]  MASTER_RST  = 8'h80;      // Starts in configuration mode
    localparam logic [7:0]  CFG_RST     = 8'h00;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CTL_DIV         = 2;      // System clocks per controller clock
    localparam int unsigned MIN_BIT_CTL     = 10;     // Least bit in controller clocks
    localparam logic [1:0]  PROC_CTL_CYCLES = 2'h3;   // Processing interval
    localparam logic [7:0]  TRIPLE_MIN_PSC  = 8'h04;  // Prescaler floor for triple sample

    typedef logic [4:0] quanta_t;                     // Segment length in quanta
    localparam quanta_t Q_ONE = 5'h01;

    typedef enum logic [1:0] {ST_SYNC, ST_PH1, ST_PH2} bit_state_t;

endpackage : can_btm_pkg

//--- tq_link_if.sv
`timescale 1ns/1ps
// Carries the controller clock phase and the prescaler to the quantum generator
interface tq_link_if;
    logic       ctl_en;                               // Controller clock cycle marker
    logic       hold;                                 // Keeps the divider at zero
    logic [7:0] prescaler;                            // Quantum prescaler field
    logic       tq_tick;                              // Last controller cycle of a quantum

    modport gen  (input ctl_en, input hold, input prescaler, output tq_tick);
    modport user (output ctl_en, output hold, output prescaler, input tq_tick);
endinterface : tq_link_if

//--- tq_prescaler.sv
`timescale 1ns/1ps
module tq_prescaler (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    tq_link_if.gen    link
);
    import can_btm_pkg::*;

    logic [7:0] div_q;                                // Controller clocks into quantum
    logic [7:0] div_d;
    wire        last_w = (div_q == link.prescaler);   // Final controller clock

    ////////////////////////////////////////////////////////////////////////////
    // Tick is combinational so it lines up with a controller clock cycle
    assign link.tq_tick = link.ctl_en & last_w & ~link.hold;

    // Wrap after prescaler plus one controller clocks
    assign div_d = link.hold ? 8'h00 :
                   (link.ctl_en ? (last_w ? 8'h00 : 8'(div_q + 8'h01)) : div_q);

    // Divider register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_d;
        end
    end

endmodule : tq_prescaler

//--- can_bit_timing_generator.sv
`timescale 1ns/1ps
// Overview of operation
// - Quantum lasts prescaler plus one controller clocks
// - Sync segment is always one quantum
// - Bit equals sync plus both phase segments
// - Phase fields give value plus one quanta
// - Three controller clocks processing after sample point
// - Resync moves bit edge by at most jump width
// - Resynchronise on at most one recessive to dominant edge per bit
// - Triple sample takes majority of three samples
// - Prescaler below four forces single sample
// - Field layout in the two bytes, zero reset
// - Timing writes only in configuration mode
// - Eight bit prescaler, any value accepted
module can_bit_timing_generator (
    input  wire logic                           clk_sys_i,
    input  wire logic                           rst_i,
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [can_btm_pkg::ADDR_W-1:0] adr_i,
    input  wire logic [3:0]                     sel_i,
    input  wire logic [31:0]                    dat_i,
    output logic      [31:0]                    dat_o,
    output logic                                ack_o,
    input  wire logic                           can_rx_i,
    output logic                                sample_point_o,
    output logic                                bit_start_o,
    output logic                                bit_done_o,
    output logic                                rx_bit_o
);
    import can_btm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic            ctl_en_q;                        // High every other system clock
    logic            ack_q;                           // Bus answer
    logic [31:0]     dat_q;                           // Read data
    logic            cfg_mode_q;                      // Configuration mode
    logic [7:0]      psc_q;                           // Quantum prescaler
    logic [7:0]      seg_q;                           // Segment timing byte
    logic [1:0]      sjw_q;                           // Jump width code
    logic [2:0]      rx_hist_q;                       // Controller clock samples of rx
    logic            edge_pend_q;                     // Falling edge in this quantum
    bit_state_t      state_q, state_d;                // Segment in progress
    quanta_t         cnt_q, cnt_d;                    // Quanta done in segment
    quanta_t         len_q, len_d;                    // Length of current segment
    logic            rsync_q, rsync_d;                // Bit already resynchronised
    logic            sampled_q;                       // Level taken at sample point
    logic [1:0]      proc_q;                          // Processing interval countdown
    logic            sp_fire, bs_fire;                // Sample point, bit start events
    logic            samp_o_q, bs_o_q, done_o_q, rx_o_q;
    logic [31:0]     rd_d;

    tq_link_if link ();

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire [IDX_W-1:0] idx_w     = adr_i[ADDR_W-1:2];
    wire             bus_req   = cyc_i & stb_i;
    wire             hit_mcr   = (idx_w == IDX_MASTER_CTRL);
    wire             hit_psc   = (idx_w == IDX_CONFIG_ONE);
    wire             hit_seg   = (idx_w == IDX_SEG_LOW);
    wire             hit_sjw   = (idx_w == IDX_JUMP_HIGH);
    wire             hit_stat  = (idx_w == IDX_STATUS);
    // Writes land on the edge where the master sees ack
    wire             wr_fire   = bus_req & we_i & ack_q & sel_i[0];
    wire             cfg_wr    = wr_fire & cfg_mode_q;

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_d = RD_ZERO;
        if (hit_mcr) begin
            rd_d[CFG_REQ_BIT] = cfg_mode_q;
        end else if (hit_psc) begin
            rd_d[7:0] = psc_q;
        end else if (hit_seg) begin
            rd_d[7:0] = seg_q;
        end else if (hit_sjw) begin
            rd_d[SJW_MSB:SJW_LSB] = sjw_q;
        end else if (hit_stat) begin
            rd_d[4:0] = {state_q, rsync_q, sampled_q, rx_o_q};
        end
    end

    // Answer one cycle after the request, drop it the cycle after
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= RD_ZERO;
        end else begin
            ack_q <= bus_req & ~ack_q;
            dat_q <= (bus_req & ~ack_q) ? rd_d : dat_q;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_mode_q <= MASTER_RST[CFG_REQ_BIT];
            psc_q <= CFG_RST;
            seg_q <= CFG_RST;
            sjw_q <= CFG_RST[SJW_MSB:SJW_LSB];
        end else begin
            if (wr_fire && hit_mcr) cfg_mode_q <= dat_i[CFG_REQ_BIT];
            if (cfg_wr && hit_psc) psc_q <= dat_i[7:0];
            if (cfg_wr && hit_seg) seg_q <= dat_i[7:0];
            if (cfg_wr && hit_sjw) sjw_q <= dat_i[SJW_MSB:SJW_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Controller clock is the system clock halved, kept as a phase marker
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) ctl_en_q <= 1'b0;
        else       ctl_en_q <= ~ctl_en_q;
    end

    assign link.ctl_en    = ctl_en_q;
    assign link.hold      = cfg_mode_q;
    assign link.prescaler = psc_q;

    tq_prescaler u_tq (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .link      (link)
    );

    wire tq_tick = link.tq_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded timing fields
    wire quanta_t ph1_len  = quanta_t'(seg_q[PH1_MSB:PH1_LSB]) + Q_ONE;
    wire quanta_t ph2_len  = quanta_t'(seg_q[PH2_MSB:PH2_LSB]) + Q_ONE;
    wire quanta_t sjw_len  = quanta_t'(sjw_q) + Q_ONE;
    // Slow prescalers only; fast ones leave no room for three samples
    wire triple_en = seg_q[TRIPLE_BIT] & (psc_q >= TRIPLE_MIN_PSC);

    // Bus edge seen on the controller clock
    wire fall_now  = ctl_en_q & rx_hist_q[0] & ~can_rx_i;
    wire edge_seen = edge_pend_q | fall_now;
    wire resync_ok = edge_seen & ~rsync_q;
    wire maj_w     = (can_rx_i & rx_hist_q[0]) | (can_rx_i & rx_hist_q[1]) |
                     (rx_hist_q[0] & rx_hist_q[1]);
    wire sample_w  = triple_en ? maj_w : can_rx_i;

    wire quanta_t cnt_inc  = cnt_q + Q_ONE;
    wire quanta_t grow_w   = (cnt_inc > sjw_len) ? sjw_len : cnt_inc;
    wire quanta_t remain_w = len_q - cnt_q;
    wire quanta_t len_cut  = len_q - sjw_len;

    // Edge history and pending edge; the pending edge is cleared at every quantum tick, used or not
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_hist_q   <= 3'h7;
            edge_pend_q <= 1'b0;
        end else begin
            if (ctl_en_q) rx_hist_q <= {rx_hist_q[1:0], can_rx_i};
            edge_pend_q <= tq_tick ? 1'b0 : edge_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment sequencer, advanced once per quantum
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        len_d   = len_q;
        rsync_d = rsync_q;
        sp_fire = 1'b0;
        bs_fire = 1'b0;
        if (cfg_mode_q) begin
            // Held idle so reconfiguration starts a clean bit
            state_d = ST_SYNC;
            cnt_d   = '0;
            len_d   = Q_ONE;
            rsync_d = 1'b0;
        end else if (tq_tick) begin
            unique case (state_q)
                ST_SYNC: begin
                    state_d = ST_PH1;
                    cnt_d   = '0;
                    len_d   = ph1_len;
                end
                ST_PH1: begin
                    cnt_d = cnt_inc;
                    if (resync_ok) begin
                        // Late edge: stretch phase one
                        len_d   = len_q + grow_w;
                        rsync_d = 1'b1;
                    end else if (cnt_inc >= len_q) begin
                        state_d = ST_PH2;
                        cnt_d   = '0;
                        len_d   = ph2_len;
                        sp_fire = 1'b1;
                    end
                end
                ST_PH2: begin
                    cnt_d = cnt_inc;
                    if (resync_ok && remain_w <= sjw_len) begin
                        // Early edge within reach: it becomes the next sync
                        state_d = ST_PH1;
                        cnt_d   = '0;
                        len_d   = ph1_len;
                        rsync_d = 1'b0;
                        bs_fire = 1'b1;
                    end else if (resync_ok) begin
                        len_d   = len_cut;
                        rsync_d = 1'b1;
                        if (cnt_inc >= len_cut) begin
                            state_d = ST_SYNC;
                            rsync_d = 1'b0;
                            bs_fire = 1'b1;
                        end
                    end else if (cnt_inc >= len_q) begin
                        state_d = ST_SYNC;
                        rsync_d = 1'b0;
                        bs_fire = 1'b1;
                    end
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_SYNC;
            cnt_q   <= '0;
            len_q   <= Q_ONE;
            rsync_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            len_q   <= len_d;
            rsync_q <= rsync_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample capture and processing interval
    wire proc_done = ctl_en_q & (proc_q == 2'h1);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sampled_q <= 1'b1;
            proc_q    <= 2'h0;
        end else begin
            if (sp_fire) sampled_q <= sample_w;
            if (sp_fire) proc_q <= PROC_CTL_CYCLES;
            else if (ctl_en_q && proc_q != 2'h0) proc_q <= proc_q - 2'h1;
        end
    end

    // Output flops
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            samp_o_q <= 1'b0;
            bs_o_q   <= 1'b0;
            done_o_q <= 1'b0;
            rx_o_q   <= 1'b1;
        end else begin
            samp_o_q <= sp_fire;
            bs_o_q   <= bs_fire;
            done_o_q <= proc_done;
            if (proc_done) rx_o_q <= sampled_q;
        end
    end

    assign dat_o          = dat_q;
    assign ack_o          = ack_q;
    assign sample_point_o = samp_o_q;
    assign bit_start_o    = bs_o_q;
    assign bit_done_o     = done_o_q;
    assign rx_bit_o       = rx_o_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    logic [9:0] gap_q;                                // System clocks since last quantum
    logic       gap_ok_q;                             // A full gap was measured
    logic [5:0] bit_tq_q;                             // Quanta in current bit

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q    <= 10'h001;
            gap_ok_q <= 1'b0;
            bit_tq_q <= 6'h00;
        end else begin
            gap_q    <= tq_tick ? 10'h001 : 10'(gap_q + 10'h001);
            gap_ok_q <= cfg_mode_q ? 1'b0 : (gap_ok_q | tq_tick);
            if (tq_tick) bit_tq_q <= (state_q == ST_SYNC || bs_fire) ? 6'h01 :
                                     6'(bit_tq_q + 6'h01);
        end
    end

    property p_tq_period;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tq_tick && gap_ok_q && !cfg_mode_q) |-> (gap_q == 10'(CTL_DIV * (psc_q + 1)));
    endproperty
    a_tq_period: assert property (p_tq_period) else $error("quantum period wrong");

    property p_sync_one;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tq_tick && !cfg_mode_q && state_q == ST_SYNC) |=> (state_q == ST_PH1 && len_q == ph1_len);
    endproperty
    a_sync_one: assert property (p_sync_one) else $error("sync segment not one quantum");

    property p_bit_len;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tq_tick && !cfg_mode_q && state_q == ST_PH2 && state_d == ST_SYNC && !rsync_q &&
         !edge_seen)
        |-> (6'(bit_tq_q + 6'h01) == 6'(ph1_len + ph2_len + Q_ONE));
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("nominal bit length wrong");

    property p_ph2_len;
        @(posedge clk_sys_i) disable iff (rst_i)
        sample_point_o |-> (state_q == ST_PH2 && cnt_q == '0 && len_q == ph2_len);
    endproperty
    a_ph2_len: assert property (p_ph2_len) else $error("phase two length wrong");

    property p_proc;
        @(posedge clk_sys_i) disable iff (rst_i)
        sample_point_o |-> !bit_done_o [*6] ##1 bit_done_o;
    endproperty
    a_proc: assert property (p_proc) else $error("processing interval not three clocks");

    property p_shorten;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tq_tick && !cfg_mode_q && state_q == ST_PH2 && resync_ok && remain_w > sjw_len)
        |=> (len_q == $past(len_q) - $past(sjw_len));
    endproperty
    a_shorten: assert property (p_shorten) else $error("phase two not cut by jump width");

    property p_lengthen;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tq_tick && !cfg_mode_q && state_q == ST_PH1 && resync_ok)
        |=> (len_q > $past(len_q)) && (len_q - $past(len_q) <= $past(sjw_len));
    endproperty
    a_lengthen: assert property (p_lengthen) else $error("late edge not absorbed");

    property p_triple;
        @(posedge clk_sys_i) disable iff (rst_i)
        (sp_fire && triple_en) |=> (sampled_q == $past(maj_w));
    endproperty
    a_triple: assert property (p_triple) else $error("majority sample wrong");

    property p_single;
        @(posedge clk_sys_i) disable iff (rst_i)
        (sp_fire && psc_q < TRIPLE_MIN_PSC) |=> (sampled_q == $past(can_rx_i));
    endproperty
    a_single: assert property (p_single) else $error("fast prescaler not single sample");

    property p_cfg_lock;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_fire && !cfg_mode_q) |=> ($stable(seg_q) && $stable(psc_q) && $stable(sjw_q));
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("timing written outside config");

    c_lengthen: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        tq_tick && !cfg_mode_q && state_q == ST_PH1 && resync_ok);
    c_shortcut: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        tq_tick && !cfg_mode_q && state_q == ST_PH2 && resync_ok && remain_w <= sjw_len);
    c_triple: cover property (@(posedge clk_sys_i) disable iff (rst_i) sp_fire && triple_en);
    c_cfg_write: cover property (@(posedge clk_sys_i) disable iff (rst_i) cfg_wr && hit_seg);

endmodule : can_bit_timing_generator

//--- can_remote_node.sv
`timescale 1ns/1ps
// Stands for the other nodes on the shared bus; idle bus is recessive by pull-up
module can_remote_node (
    input  wire logic clk_sys_i,
    output logic      bus_o
);
    // Recessive from time zero, as the pull-up would hold it
    initial begin
        bus_o = 1'b1;
    end

    // Level change just after an edge; a fall here is a resync edge for the device
    task automatic drive(input logic lvl);
        @(posedge clk_sys_i);
        bus_o <= lvl;
    endtask : drive
endmodule : can_remote_node

//--- can_bit_timing_generator_tb_top.sv
`timescale 1ns/1ps
module can_bit_timing_generator_tb_top;
    logic        clk_sys_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [11:0] adr_i     = 12'h000;
    logic [3:0]  sel_i     = 4'h0;
    logic [31:0] dat_i     = 32'h0000_0000, dat_o, q;
    logic        ack_o, bus, sample_point_o, bit_start_o, bit_done_o, rx_bit_o;
    int          error_cnt = 0, checked = 0, cnt = 0, t0, t1, t2, t3;

    can_bit_timing_generator dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .can_rx_i(bus), .sample_point_o(sample_point_o),
        .bit_start_o(bit_start_o), .bit_done_o(bit_done_o), .rx_bit_o(rx_bit_o));
    can_remote_node node (.clk_sys_i(clk_sys_i), .bus_o(bus));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and cycle count used as a time base for pulse spacing
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) cnt <= cnt + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
        if (n >= 50) chk(1'b0, 1'b1);
    endtask : wb

    // Wait for a pulse: 0 bit start, 1 sample point, 2 bit done
    task automatic wp(input int k, output int t);
        int n;
        logic s;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
            s = (k == 0) ? bit_start_o : (k == 1) ? sample_point_o : bit_done_o;
        end while (s !== 1'b1 && n < 2000);
        t = cnt;
        if (n >= 2000) chk(1'b0, 1'b1);
    endtask : wp

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, read back, unmapped place
    task automatic t_regs();
        wb(0, 12'hC78, 0); chk(q, 32'h0000_0000);
        wb(0, 12'hC7C, 0); chk(q, 32'h0000_0000);
        wb(1, 12'hC70, 32'h0000_00FF); wb(0, 12'hC70, 0); chk(q, 32'h0000_00FF);
        wb(1, 12'hC7C, 32'h0000_0003); wb(0, 12'hC7C, 0); chk(q, 32'h0000_0003);
        wb(0, 12'h004, 0); chk(q, 32'h0000_0000);
    endtask : t_regs

    // Prescaler 1: quantum 4 clocks; 1+7+2 quanta = 40 clocks a bit; jump 2 quanta
    task automatic t_timing();
        wb(1, 12'hC70, 32'h0000_0001);
        wb(1, 12'hC78, 32'h0000_0096);
        wb(1, 12'hC7C, 32'h0000_0001);
        wb(1, 12'hC60, 32'h0000_0000);
        wp(0, t0); wp(1, t1); chk(t1 - t0, 32);
        wp(2, t2); chk(t2 - t1, 6);
        wp(0, t3); chk(t3 - t0, 40);
        wp(1, t2); chk(t2 - t1, 40);
        wb(1, 12'hC78, 32'h0000_0011); wb(0, 12'hC78, 0); chk(q, 32'h0000_0096);
    endtask : t_timing

    // Falling edge three quanta into a bit; single sample below prescaler 4
    task automatic t_resync();
        wp(0, t0);
        repeat (11) @(posedge clk_sys_i);
        node.drive(1'b0);
        wp(2, t1); chk(rx_bit_o, 1'b0);
        wp(0, t3); chk(t3 - t0, 48);
        node.drive(1'b1);
        wp(2, t1); chk(rx_bit_o, 1'b1);
    endtask : t_resync

    // Prescaler 4: quantum 10 clocks, triple sample on, jump 1 quantum
    task automatic t_triple();
        wb(1, 12'hC60, 32'h0000_0080);
        wb(1, 12'hC70, 32'h0000_0004);
        wb(1, 12'hC7C, 32'h0000_0000);
        node.drive(1'b0);
        wb(1, 12'hC60, 32'h0000_0000);
        wp(0, t0);
        repeat (77) @(posedge clk_sys_i);
        // Only the last of three samples sees the rise
        node.drive(1'b1);
        wp(1, t1); chk(t1 - t0, 80);
        wp(2, t2); chk(rx_bit_o, 1'b0);
        // Fall in the first phase two quantum cuts the bit by one quantum
        node.drive(1'b0);
        wp(0, t3); chk(t3 - t0, 90);
    endtask : t_triple

    task automatic end_of_test();
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    // Whole run is about seven bits; far beyond that means a hang
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_regs();
        t_timing();
        t_resync();
        t_triple();
        end_of_test();
    end
endmodule : can_bit_timing_generator_tb_top
